// ==== design/timer_pkg.sv ====
// Constants shared by the timer block: register map, fields, reset values
//
// Contract
// - Compare match fires in the last state where count equals compare value.
// - On compare match, the pin takes the level set in pin output control.
// - No further compare match until the next counter input clock pulse.
// - A status flag clears when software reads it as 1, then writes 0.
// - After reset the unit sits in standby; registers reachable only once released.
// - With clear on match, count clears in the last state equal to compare; the code clears on a compare A match only.
// - Normal channels cycle at clock over N+1; late-clear mode over N.
// - Compare match or capture sets the match flag and raises its request.
// - Wrap FFFF to 0 sets overflow flag; down through zero sets underflow flag.
// - Match request is high only while its enable bit and flag are set.
// - Overflow and underflow requests gated by their enables and their flags.
package timer_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PIN_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_CMP_A = 8'h14;
    localparam logic [7:0] OFS_CMP_B = 8'h18;
    localparam logic [7:0] OFS_STANDBY = 8'h1C;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTL_RUN = 0;
    localparam int CTL_SRC_LO = 1;
    localparam int CTL_CLR_MATCH = 3;
    localparam int CTL_LATE_CLR = 4;
    localparam int CTL_DOWN = 5;
    localparam int CTL_CAP_LO = 6;
    localparam int CTL_WIDTH = 8;

    // Clock source selection
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_EXT_RISE = 2'h1;
    localparam int SRC_EXT_BOTH_I = 2;
    localparam logic [1:0] SRC_EXT_BOTH = 2'h2;
    localparam logic [1:0] SRC_PHASE = 2'h3;

    // Pin actions on compare match
    localparam logic [1:0] PIN_NONE = 2'h0;
    localparam logic [1:0] PIN_LOW = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    localparam logic [1:0] PIN_TOGGLE = 2'h3;

    // Status and enable bit positions
    localparam int ST_MATCH_A = 0;
    localparam int ST_OVF = 2;
    localparam int ST_UNF = 3;
    localparam int ST_WIDTH = 4;

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [3:0] PIN_CTRL_RST = 4'h0;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'hFFFF;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic STANDBY_RST = 1'b1;
    localparam int NUM_CMP = 2;
endpackage : timer_pkg

// ==== design/clock_input_decoder.sv ====
// Counter input clock decoder: internal, external edge and phase counting
`timescale 1ns/10ps
module clock_input_decoder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] src,
    input wire logic clk_a,
    input wire logic clk_b,
    output logic tick,
    output logic down
);
    logic a_prev_r;
    logic b_prev_r;
    logic a_edge;
    logic b_edge;
    logic tick_nxt;

    // Edge detection on the external inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
        end else begin
            a_prev_r <= clk_a;
            b_prev_r <= clk_b;
        end
    end

    assign a_edge = clk_a ^ a_prev_r;
    assign b_edge = clk_b ^ b_prev_r;

    // Count pulse per selected source
    always_comb begin
        case (src)
            timer_pkg::SRC_INTERNAL: tick_nxt = 1'b1;
            timer_pkg::SRC_EXT_RISE: tick_nxt = a_edge & clk_a;
            timer_pkg::SRC_EXT_BOTH: tick_nxt = a_edge;
            default: tick_nxt = a_edge | b_edge;
        endcase
    end

    // Registered tick; phase mode derives direction from quadrature order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
            down <= 1'b0;
        end else begin
            tick <= tick_nxt;
            if (src == timer_pkg::SRC_PHASE && (a_edge || b_edge)) begin
                down <= a_edge ? ~(clk_a ^ clk_b) : (clk_a ^ clk_b);
            end
        end
    end
endmodule : clock_input_decoder

// ==== design/compare_pin_driver.sv ====
// Compare output pin driver for one compare/capture register
`timescale 1ns/10ps
module compare_pin_driver (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [1:0] action,
    input wire logic match,
    output logic pin_o,
    output logic pin_oe
);
    // Pin level updates on each compare match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= enable && (action != timer_pkg::PIN_NONE);
            if (match) begin
                case (action)
                    timer_pkg::PIN_LOW: pin_o <= 1'b0;
                    timer_pkg::PIN_HIGH: pin_o <= 1'b1;
                    timer_pkg::PIN_TOGGLE: pin_o <= ~pin_o;
                    default: pin_o <= pin_o;
                endcase
            end
        end
    end
endmodule : compare_pin_driver

// ==== design/multi_channel_timer_timing.sv ====
// Timer channel with compare/capture, flags, interrupts and APB registers
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module multi_channel_timer_timing (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clk_a,
    input wire logic ext_clk_b,
    input wire logic [1:0] capture_in,
    output logic [1:0] timer_io_pin_o,
    output logic [1:0] timer_io_pin_oe,
    output logic [1:0] match_interrupt,
    output logic overflow_interrupt,
    output logic underflow_interrupt,
    output logic irq
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0] control_r;
    logic [3:0] pin_output_control_r;
    logic [3:0] timer_status_reg_r;
    logic [3:0] interrupt_enable_reg_r;
    logic [3:0] read_armed_r;
    logic [15:0] timer_count_r;
    logic [15:0] timer_count_nxt;
    logic [15:0] count_step;
    logic [15:0] compare_capture_reg_r [timer_pkg::NUM_CMP];
    logic standby_r;
    logic [1:0] cap_prev_r;
    logic [1:0] cap_pend_r;
    logic [1:0] cap_evt;
    logic [1:0] match;
    logic [3:0] status_set;
    logic [3:0] status_clr;
    logic tick;
    logic ext_down;
    logic down;
    logic running;
    logic overflow;
    logic underflow;
    logic setup_phase;
    logic access_wr;
    logic access_rd;
    logic [31:0] rdata_nxt;
    logic err_nxt;

    // Address decode used by read mux, writes and error
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, timer_pkg::OFS_CONTROL) || hit(addr, timer_pkg::OFS_PIN_CTRL)
            || hit(addr, timer_pkg::OFS_STATUS) || hit(addr, timer_pkg::OFS_IRQ_EN)
            || hit(addr, timer_pkg::OFS_COUNT) || hit(addr, timer_pkg::OFS_CMP_A)
            || hit(addr, timer_pkg::OFS_CMP_B) || hit(addr, timer_pkg::OFS_STANDBY);
    endfunction : mapped

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign setup_phase = psel && !penable;
    assign access_wr = psel && penable && pready && pwrite && !pslverr;
    assign access_rd = psel && penable && pready && !pwrite && !pslverr;

    // Registers other than standby are closed while in standby
    always_comb begin
        err_nxt = !mapped(paddr)
            || (standby_r && !hit(paddr, timer_pkg::OFS_STANDBY));
        rdata_nxt = 32'h00000000;
        if (!err_nxt) begin
            case (paddr)
                timer_pkg::OFS_CONTROL: rdata_nxt = {24'h000000, control_r};
                timer_pkg::OFS_PIN_CTRL: rdata_nxt = {28'h0000000, pin_output_control_r};
                timer_pkg::OFS_STATUS: rdata_nxt = {28'h0000000, timer_status_reg_r};
                timer_pkg::OFS_IRQ_EN: rdata_nxt = {28'h0000000, interrupt_enable_reg_r};
                timer_pkg::OFS_COUNT: rdata_nxt = {16'h0000, timer_count_r};
                timer_pkg::OFS_CMP_A: rdata_nxt = {16'h0000, compare_capture_reg_r[0]};
                timer_pkg::OFS_CMP_B: rdata_nxt = {16'h0000, compare_capture_reg_r[1]};
                timer_pkg::OFS_STANDBY: rdata_nxt = {31'h00000000, standby_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Answer prepared in the setup cycle; zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                prdata <= pwrite ? 32'h00000000 : rdata_nxt;
                pslverr <= err_nxt;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_r <= timer_pkg::CONTROL_RST;
            pin_output_control_r <= timer_pkg::PIN_CTRL_RST;
            interrupt_enable_reg_r <= 4'h0;
            standby_r <= timer_pkg::STANDBY_RST;
        end else if (access_wr) begin
            if (hit(paddr, timer_pkg::OFS_CONTROL)) begin
                control_r <= pwdata[timer_pkg::CTL_WIDTH-1:0];
            end
            if (hit(paddr, timer_pkg::OFS_PIN_CTRL)) begin
                pin_output_control_r <= pwdata[3:0];
            end
            if (hit(paddr, timer_pkg::OFS_IRQ_EN)) begin
                interrupt_enable_reg_r <= pwdata[3:0];
            end
            if (hit(paddr, timer_pkg::OFS_STANDBY)) begin
                standby_r <= pwdata[0];
            end
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    clock_input_decoder u_clock_input_decoder (
        .pclk(pclk),
        .presetn(presetn),
        .src(control_r[timer_pkg::CTL_SRC_LO +: 2]),
        .clk_a(ext_clk_a),
        .clk_b(ext_clk_b),
        .tick(tick),
        .down(ext_down)
    );

    assign running = !standby_r && control_r[timer_pkg::CTL_RUN];
    assign down = (control_r[timer_pkg::CTL_SRC_LO +: 2] == timer_pkg::SRC_PHASE)
        ? ext_down : control_r[timer_pkg::CTL_DOWN];
    assign count_step = down ? timer_count_r - 16'h0001 : timer_count_r + 16'h0001;
    assign overflow = running && tick && !down && timer_count_r == timer_pkg::COUNT_MAX;
    assign underflow = running && tick && down && timer_count_r == timer_pkg::COUNT_ZERO;

    // Write beats clear, clear beats counting
    always_comb begin
        timer_count_nxt = timer_count_r;
        if (access_wr && hit(paddr, timer_pkg::OFS_COUNT)) begin
            timer_count_nxt = pwdata[15:0];
        end else if (match[0] && control_r[timer_pkg::CTL_CLR_MATCH]) begin
            timer_count_nxt = timer_pkg::COUNT_ZERO;
        end else if (running && tick) begin
            timer_count_nxt = count_step;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count_r <= timer_pkg::COUNT_RST;
        end else begin
            timer_count_r <= timer_count_nxt;
        end
    end

    // ----------------------------------------
    // Compare and capture, one slice per register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_prev_r <= 2'h0;
            cap_pend_r <= 2'h0;
        end else begin
            cap_prev_r <= capture_in;
            cap_pend_r <= cap_evt;
        end
    end

    for (genvar i = 0; i < timer_pkg::NUM_CMP; i++) begin : g_cmp
        logic cap_en;
        logic [7:0] cmp_ofs;
        assign cap_en = control_r[timer_pkg::CTL_CAP_LO + i];
        assign cmp_ofs = i == 0 ? timer_pkg::OFS_CMP_A : timer_pkg::OFS_CMP_B;
        assign cap_evt[i] = !standby_r && cap_en && capture_in[i] && !cap_prev_r[i];

        // Match only on a count pulse; late mode matches one step earlier
        assign match[i] = running && tick && !cap_en
            && ((control_r[timer_pkg::CTL_LATE_CLR] ? count_step : timer_count_r)
                == compare_capture_reg_r[i]);

        // Capture takes precedence over a software write
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                compare_capture_reg_r[i] <= timer_pkg::CMP_RST;
            end else if (cap_pend_r[i]) begin
                compare_capture_reg_r[i] <= timer_count_r;
            end else if (access_wr && hit(paddr, cmp_ofs)) begin
                compare_capture_reg_r[i] <= pwdata[15:0];
            end
        end

        compare_pin_driver u_compare_pin_driver (
            .pclk(pclk),
            .presetn(presetn),
            .enable(!cap_en),
            .action(pin_output_control_r[2*i +: 2]),
            .match(match[i]),
            .pin_o(timer_io_pin_o[i]),
            .pin_oe(timer_io_pin_oe[i])
        );
    end

    // ----------------------------------------
    // Status flags and interrupts
    // ----------------------------------------
    assign status_set = {underflow, overflow, match | cap_pend_r};
    assign status_clr = (access_wr && hit(paddr, timer_pkg::OFS_STATUS))
        ? (read_armed_r & ~pwdata[3:0]) : 4'h0;

    // Flags: set wins over clear; a read of 1 arms the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_status_reg_r <= 4'h0;
            read_armed_r <= 4'h0;
        end else begin
            timer_status_reg_r <= (timer_status_reg_r & ~status_clr) | status_set;
            if (access_rd && hit(paddr, timer_pkg::OFS_STATUS)) begin
                read_armed_r <= read_armed_r | timer_status_reg_r;
            end else if (access_wr && hit(paddr, timer_pkg::OFS_STATUS)) begin
                read_armed_r <= 4'h0;
            end
        end
    end

    // Requests follow flag and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_interrupt <= 2'h0;
            overflow_interrupt <= 1'b0;
            underflow_interrupt <= 1'b0;
            irq <= 1'b0;
        end else begin
            match_interrupt <= timer_status_reg_r[1:0] & interrupt_enable_reg_r[1:0];
            overflow_interrupt <= timer_status_reg_r[timer_pkg::ST_OVF]
                && interrupt_enable_reg_r[timer_pkg::ST_OVF];
            underflow_interrupt <= timer_status_reg_r[timer_pkg::ST_UNF]
                && interrupt_enable_reg_r[timer_pkg::ST_UNF];
            irq <= |(timer_status_reg_r & interrupt_enable_reg_r);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence match_a_high_s;
        match[0] && pin_output_control_r[1:0] == timer_pkg::PIN_HIGH;
    endsequence

    sequence capture_a_s;
        cap_evt[0] ##1 !(access_wr && hit(paddr, timer_pkg::OFS_COUNT));
    endsequence

    a_match_needs_tick: assert property (@(posedge pclk) disable iff (!presetn)
        match[0] |-> tick && running)
        else $error("compare match without count pulse");

    a_pin_drives_high: assert property (@(posedge pclk) disable iff (!presetn)
        match_a_high_s |=> timer_io_pin_o[0])
        else $error("pin not driven high after match");

    a_clear_on_match: assert property (@(posedge pclk) disable iff (!presetn)
        match[0] && control_r[timer_pkg::CTL_CLR_MATCH]
            && !(access_wr && hit(paddr, timer_pkg::OFS_COUNT))
        |=> timer_count_r == timer_pkg::COUNT_ZERO)
        else $error("count not cleared on match");

    a_flag_on_match: assert property (@(posedge pclk) disable iff (!presetn)
        match[1] |=> timer_status_reg_r[1])
        else $error("match flag not set");

    a_overflow_flag: assert property (@(posedge pclk) disable iff (!presetn)
        overflow |=> timer_status_reg_r[timer_pkg::ST_OVF] ##1 overflow_interrupt
            || !interrupt_enable_reg_r[timer_pkg::ST_OVF])
        else $error("overflow flag or request missing");

    a_match_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        match_interrupt[0] |-> $past(timer_status_reg_r[0] && interrupt_enable_reg_r[0]))
        else $error("match request without flag and enable");

    a_underflow_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !timer_status_reg_r[timer_pkg::ST_UNF] |=> !underflow_interrupt)
        else $error("underflow request without flag");

    a_standby_holds: assert property (@(posedge pclk) disable iff (!presetn)
        standby_r |=> $stable(timer_count_r) && $stable(control_r))
        else $error("timer changed while in standby");

    a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
        capture_a_s |=> compare_capture_reg_r[0] == $past(timer_count_r))
        else $error("capture register not loaded");

    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        status_clr[0] && !status_set[0] |=> !timer_status_reg_r[0])
        else $error("flag not cleared by write of zero");
endmodule : multi_channel_timer_timing

// ==== testbench/timer_far_side.sv ====
// Far-side model: external count clocks and capture inputs of the timer
`timescale 1ns/10ps
module timer_far_side (
    input wire logic pclk,
    output logic ext_clk_a,
    output logic ext_clk_b,
    output logic [1:0] capture_in
);
    // ----------------------------------------
    // Idle state
    // ----------------------------------------
    // Inputs stand still low outside bursts
    initial begin
        ext_clk_a = 1'b0;
        ext_clk_b = 1'b0;
        capture_in = 2'h0;
    end

    // Pulses on clock A, each level held w cycles (2 for one edge, 3 for both)
    task automatic pulses(input int k, input int w);
        for (int i = 0; i < k; i++) begin
            ext_clk_a <= 1'b1;
            repeat (w) @(posedge pclk);
            ext_clk_a <= 1'b0;
            repeat (w) @(posedge pclk);
        end
    endtask : pulses

    // Quadrature steps held 2 cycles each, so every pulse lasts 8 cycles
    task automatic quad(input int k, input bit up);
        logic [1:0] q [4];
        q = '{2'b00, 2'b10, 2'b11, 2'b01};
        for (int i = 0; i < 4 * k; i++) begin
            {ext_clk_a, ext_clk_b} <= up ? q[(i + 1) % 4] : q[3 - (i % 4)];
            repeat (2) @(posedge pclk);
        end
    endtask : quad

    // One capture pulse, wide enough for the input edge detector
    task automatic capture(input int idx);
        capture_in[idx] <= 1'b1;
        repeat (3) @(posedge pclk);
        capture_in[idx] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : capture
endmodule : timer_far_side

// ==== testbench/multi_channel_timer_timing_tb.sv ====
// Self-checking bench for the timer block, driven over APB
`timescale 1ns/10ps
module multi_channel_timer_timing_tb;
    typedef struct packed {logic err; logic [31:0] mask; logic [31:0] data;} expect_t;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_clk_a;
    logic ext_clk_b;
    logic [1:0] capture_in;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;
    logic [1:0] match_irq;
    logic ovf_irq;
    logic unf_irq;
    logic irq;
    int mismatches;
    int samples_checked;
    expect_t exp_q[$];
    expect_t mon_e;
    logic [31:0] rd;
    logic [31:0] v;
    int n;
    int per;

    // ----------------------------------------
    // Design, far side and clock
    // ----------------------------------------
    multi_channel_timer_timing dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk_a(ext_clk_a), .ext_clk_b(ext_clk_b),
        .capture_in(capture_in), .timer_io_pin_o(pin_o), .timer_io_pin_oe(pin_oe),
        .match_interrupt(match_irq), .overflow_interrupt(ovf_irq),
        .underflow_interrupt(unf_irq), .irq(irq));
    timer_far_side far_u (.pclk(pclk), .ext_clk_a(ext_clk_a), .ext_clk_b(ext_clk_b),
        .capture_in(capture_in));
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; the expected answer is queued for the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err, input logic [31:0] m, input logic [31:0] e);
        int k;
        exp_q.push_back({err, m, e});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            print_verdict();
        end else begin
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
    endtask : wr

    task automatic rdx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b0, m, e);
    endtask : rdx

    // Cycles until compare pin A changes, bounded
    task automatic wait_pin(output int cyc);
        logic p;
        p = pin_o[0];
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (pin_o[0] === p && cyc < 2000);
        if (cyc >= 2000) begin
            mismatches++;
            print_verdict();
        end
    endtask : wait_pin

    // Monitor: each completed transfer takes the oldest queued expectation
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            check("pslverr", {31'h0, mon_e.err}, {31'h0, pslverr});
            check("prdata", mon_e.data & mon_e.mask, prdata & mon_e.mask);
        end
    end

    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0;
        samples_checked = 0;
        n = $urandom(9);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("irq after reset", 32'h0, {match_irq, ovf_irq, unf_irq, irq, pin_oe});
        apb(1'b0, timer_pkg::OFS_CONTROL, 32'h0, 1'b1, 32'hFFFFFFFF, 32'h0);
        rdx(timer_pkg::OFS_STANDBY, 32'h1, 32'h1);
        wr(timer_pkg::OFS_STANDBY, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 1'b1, 32'hFFFFFFFF, 32'h0);
        rdx(timer_pkg::OFS_CMP_B, 32'hFFFF, 32'hFFFF);
        // Pin levels on compare match, then period with toggling
        n = 4 + ($urandom % 16);
        wr(timer_pkg::OFS_CMP_A, n);
        for (int a = 2; a >= 1; a--) begin
            wr(timer_pkg::OFS_CONTROL, 32'h0);
            wr(timer_pkg::OFS_COUNT, 32'h0);
            wr(timer_pkg::OFS_PIN_CTRL, a);
            wr(timer_pkg::OFS_CONTROL, 32'h09);
            repeat (n + 4) @(posedge pclk);
            check("pin level", a - 1, pin_o[0]);
            check("pin enable", 32'h1, pin_oe);
        end
        wr(timer_pkg::OFS_PIN_CTRL, 32'h3);
        for (int late = 0; late < 2; late++) begin
            wr(timer_pkg::OFS_CONTROL, 32'h0);
            wr(timer_pkg::OFS_COUNT, 32'h0);
            wr(timer_pkg::OFS_CONTROL, late ? 32'h19 : 32'h09);
            wait_pin(per);
            wait_pin(per);
            check("match period", n + 1 - late, per);
        end
        wr(timer_pkg::OFS_PIN_CTRL, 32'h0);
        wr(timer_pkg::OFS_CONTROL, 32'h0);
        check("pin released", 32'h0, pin_oe);
        // Match flag, its enable and the read-then-write-zero clear
        wr(timer_pkg::OFS_IRQ_EN, 32'h0);
        check("masked match request", 32'h0, {match_irq, irq});
        wr(timer_pkg::OFS_IRQ_EN, 32'hF);
        wr(timer_pkg::OFS_STATUS, 32'h0);
        check("match request", 32'h3, {match_irq[0], irq});
        rdx(timer_pkg::OFS_STATUS, 32'h1, 32'h1);
        wr(timer_pkg::OFS_STATUS, 32'h0);
        rdx(timer_pkg::OFS_STATUS, 32'h1, 32'h0);
        check("match withdrawn", 32'h0, match_irq[0]);
        // Overflow and underflow
        wr(timer_pkg::OFS_COUNT, 32'hFFFA);
        wr(timer_pkg::OFS_CONTROL, 32'h01);
        repeat (10) @(posedge pclk);
        wr(timer_pkg::OFS_CONTROL, 32'h0);
        check("overflow request", 32'h1, ovf_irq);
        check("match B request", 32'h1, match_irq[1]);
        rdx(timer_pkg::OFS_STATUS, 32'h4, 32'h4);
        wr(timer_pkg::OFS_STATUS, 32'h0);
        rdx(timer_pkg::OFS_STATUS, 32'h4, 32'h0);
        check("overflow withdrawn", 32'h0, ovf_irq);
        wr(timer_pkg::OFS_COUNT, 32'h3);
        wr(timer_pkg::OFS_CONTROL, 32'h21);
        repeat (10) @(posedge pclk);
        wr(timer_pkg::OFS_CONTROL, 32'h0);
        check("underflow request", 32'h1, unf_irq);
        rdx(timer_pkg::OFS_STATUS, 32'hC, 32'h8);
        wr(timer_pkg::OFS_STATUS, 32'h0);
        // Capture of a held count into register A
        v = $urandom % 32'h10000;
        wr(timer_pkg::OFS_CONTROL, 32'h43);
        wr(timer_pkg::OFS_COUNT, v);
        far_u.capture(0);
        rdx(timer_pkg::OFS_CMP_A, 32'hFFFF, v);
        rdx(timer_pkg::OFS_STATUS, 32'h1, 32'h1);
        check("capture request", 32'h1, match_irq[0]);
        // External clock on one edge, both edges and phase counting
        wr(timer_pkg::OFS_COUNT, 32'h0);
        wr(timer_pkg::OFS_CONTROL, 32'h03);
        far_u.pulses(5, 2);
        rdx(timer_pkg::OFS_COUNT, 32'hFFFF, 32'h5);
        wr(timer_pkg::OFS_COUNT, 32'h0);
        wr(timer_pkg::OFS_CONTROL, 32'h05);
        far_u.pulses(5, 3);
        rdx(timer_pkg::OFS_COUNT, 32'hFFFF, 32'hA);
        wr(timer_pkg::OFS_COUNT, 32'h64);
        wr(timer_pkg::OFS_CONTROL, 32'h07);
        far_u.quad(3, 1'b1);
        rdx(timer_pkg::OFS_COUNT, 32'hFFFF, 32'h70);
        check("phase count", 32'h70, rd);
        far_u.quad(3, 1'b0);
        rdx(timer_pkg::OFS_COUNT, 32'hFFFF, 32'h64);
        print_verdict();
    end
endmodule : multi_channel_timer_timing_tb
